// ---- hw/amc_pkg.sv ----
package amc_pkg;
   localparam int DATA_W = 12;
   localparam int REG_W = 16;
   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_CONFIG = 4'h0;
   localparam logic [3:0] IDX_I_RANGE = 4'h3;
   localparam logic [3:0] IDX_Q_RANGE = 4'hb;
   localparam logic [7:0] ADDR_CONFIG = {2'h0, IDX_CONFIG, 2'h0};
   localparam logic [7:0] ADDR_I_RANGE = {2'h0, IDX_I_RANGE, 2'h0};
   localparam logic [7:0] ADDR_Q_RANGE = {2'h0, IDX_Q_RANGE, 2'h0};
   localparam logic [7:0] ADDR_STATUS = 8'h40;
   // configuration field positions
   localparam int CFG_CAL = 15;
   localparam int CFG_PHASE = 14;
   localparam int CFG_PATTERN = 12;
   localparam int CFG_I_SLEEP = 11;
   localparam int CFG_Q_SLEEP = 10;
   localparam int CFG_INTERLEAVE = 7;
   localparam int CFG_Q_INPUT = 6;
   localparam int CFG_BOTH_INPUTS = 5;
   localparam int CFG_SDR = 2;
   localparam logic [15:0] CONFIG_RESET = 16'h2000;
   localparam logic [15:0] RANGE_RESET = 16'h4000;
   // status field positions
   localparam int ST_CAL_RUN = 0;
   localparam int ST_VALID = 1;
   localparam int ST_REG_MODE = 2;
   localparam int ST_INTERLEAVE = 3;
   localparam int ST_NON_DEMUX = 4;
   localparam int ST_INPUT_SEL = 5;
   localparam int ST_PHASE_SEL = 7;
   localparam int ST_I_SLEEP = 9;
   localparam int ST_Q_SLEEP = 10;
   localparam int ST_PATTERN = 11;
   localparam int ST_RANGE_FAULT = 12;
   localparam int ST_RECAL = 13;
   localparam int ST_POR_SKIPPED = 14;
   // clock rate in MHz; timing in sampling clock cycles
   localparam int CLK_MHZ = 125;
   localparam int FLUSH_CYCLES = 60;
   localparam int TRIM_LOW_HOLD = 1280;
   localparam int TRIM_HIGH_HOLD = 1280;
   localparam int CAL_RUN_CYCLES = 4096;
   localparam int WAIT_SHORT_CYCLES = 8192;
   localparam int WAIT_LONG_CYCLES = 65536;

   typedef enum logic [1:0] {
      AMC_DDR_0 = 2'b00,
      AMC_DDR_90 = 2'b01,
      AMC_SDR_FALL = 2'b10,
      AMC_SDR_RISE = 2'b11
   } amc_phase_t;

   typedef enum logic [1:0] {
      AMC_IN_I = 2'b00,
      AMC_IN_Q = 2'b01,
      AMC_IN_BOTH = 2'b10
   } amc_input_t;

   typedef enum logic [1:0] {
      AMC_POR_WAIT = 2'b00,
      AMC_CAL = 2'b01,
      AMC_FLUSH = 2'b10,
      AMC_RUN = 2'b11
   } amc_state_t;
endpackage

// ---- hw/amc_sync.sv ----
`timescale 1ns/10ps
module amc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta <= INIT;
         synced <= INIT;
      end
      else if (ce)
      begin
         meta <= async;
         synced <= meta;
      end
   end
endmodule // amc_sync

// ---- hw/amc_mode_ctrl.sv ----
// Functional notes
// - non-demux gives full-rate single bus; demux gives half rate on two buses
// - demux choice comes only from non_demux_select pin in both control modes
// - separate channels demux 1:2 each; interleaved pair demux 1:4 or none
// - non-demux forces double rate 0 degree; demux allows 0/90 and rise/fall
// - serial enable high gives pin control, registers idle, pins rule everything
// - dual edge select high interleaves rising/falling channels, low keeps them independent
// - pin control interleaves I input only; register mode may pick Q or both
// - register control enables interleave through config bit 7
// - non_demux_select low means demux, high non-demux; bus counts follow
// - ddr_phase_select picks 0/90 at double rate, falling/rising at single rate
// - 0 degree data moves with strobe edge, 90 degree midway, both strobes alike
// - register control takes phase from config bit 14, not pin
// - trim request high at power-up skips power-on calibration
// - register control ORs calibration pin with config bit 15
// - trim_start_delay_select picks short or long power-on wait in both modes
// - high i_path_sleep powers I down and floats its buses
// - after sleep the pipeline is flushed before data counts valid
// - register control sleeps I channel on pin or config bit 11
// - q_path_sleep controls Q likewise, with config bit 10 in register mode
// - pattern select drives test pattern on all buses and overrange outputs
// - input range pin must be high; registers give per-channel range
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module amc_mode_ctrl
   import amc_pkg::*;
#(
   parameter int LOW_HOLD = TRIM_LOW_HOLD,
   parameter int HIGH_HOLD = TRIM_HIGH_HOLD,
   parameter int CAL_CYCLES = CAL_RUN_CYCLES,
   parameter int WAIT_SHORT = WAIT_SHORT_CYCLES,
   parameter int WAIT_LONG = WAIT_LONG_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serialControlEnableN,
   input wire logic dualEdgeSelect,
   input wire logic nonDemuxSelect,
   input wire logic ddrPhaseSelect,
   input wire logic trimCycleRequest,
   input wire logic trimStartDelaySelect,
   input wire logic iPathSleep,
   input wire logic qPathSleep,
   input wire logic patternOutputSelect,
   input wire logic inputRangeSelect,
   input wire logic [DATA_W-1:0] iSample,
   input wire logic [DATA_W-1:0] qSample,
   input wire logic iSampleOver,
   input wire logic qSampleOver,
   output logic [DATA_W-1:0] iOutBus,
   output logic [DATA_W-1:0] iOutBusEarly,
   output logic [DATA_W-1:0] qOutBus,
   output logic [DATA_W-1:0] qOutBusEarly,
   output logic iOutEnable,
   output logic qOutEnable,
   output logic iOverrange,
   output logic qOverrange,
   output logic iOutputStrobe,
   output logic qOutputStrobe,
   output logic calRunning,
   output logic dataValid,
   output logic [REG_W-1:0] iRange,
   output logic [REG_W-1:0] qRange
);
   localparam int CNT_W = 20;
   localparam logic [CNT_W-1:0] LOW_MAX = CNT_W'(LOW_HOLD);
   localparam logic [CNT_W-1:0] HIGH_MAX = CNT_W'(HIGH_HOLD);

   function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lim);
      satInc = (v >= lim) ? lim : v + 1'b1;
   endfunction

   logic [9:0] pinSync;
   logic regModeN;
   logic dualEdgePin;
   logic nonDemux;
   logic phasePin;
   logic trimPin;
   logic delayPin;
   logic iSleepPin;
   logic qSleepPin;
   logic patternPin;
   logic rangePin;

   // two-stage pin sync; reset as both sleep pins floating, pin control, range high
   amc_sync #(.WIDTH(10), .INIT(10'h2c1)) pinSyncer (
      .mclk(mclk),
      .resetn(resetn),
      .ce(ce),
      .async({inputRangeSelect, patternOutputSelect, qPathSleep, iPathSleep, trimStartDelaySelect,
              trimCycleRequest, ddrPhaseSelect, nonDemuxSelect, dualEdgeSelect, serialControlEnableN}),
      .synced(pinSync)
   );
   assign {rangePin, patternPin, qSleepPin, iSleepPin, delayPin, trimPin, phasePin, nonDemux, dualEdgePin,
           regModeN} = pinSync;

   logic [REG_W-1:0] configReg;
   logic [REG_W-1:0] iRangeReg;
   logic [REG_W-1:0] qRangeReg;
   logic [REG_W-1:0] statusWord;
   logic regMode;
   logic interleave;
   amc_input_t inputSel;
   amc_phase_t phaseSel;
   logic sdrMode;
   logic iSleep;
   logic qSleep;
   logic pattern;
   logic calBit;
   logic apbAccess;
   logic apbDone;
   logic mapped;

   assign regMode = ~regModeN;
   assign apbAccess = psel & penable & ~pready;
   assign apbDone = psel & penable & pready;
   assign mapped = (paddr == ADDR_CONFIG) || (paddr == ADDR_I_RANGE) || (paddr == ADDR_Q_RANGE)
                   || (paddr == ADDR_STATUS);

   // interleave from pin in pin control
   // interleave from config bit 7 in register control
   assign interleave = regMode ? configReg[CFG_INTERLEAVE] : dualEdgePin;
   // pin and register calibration requests are ORed
   assign calBit = regMode & configReg[CFG_CAL];
   assign iSleep = iSleepPin | (regMode & configReg[CFG_I_SLEEP]);
   assign qSleep = qSleepPin | (regMode & configReg[CFG_Q_SLEEP]);
   assign pattern = patternPin | (regMode & configReg[CFG_PATTERN]);
   assign sdrMode = regMode & configReg[CFG_SDR];

   always_comb
   begin
      inputSel = AMC_IN_I;
      if (regMode && configReg[CFG_BOTH_INPUTS])
         inputSel = AMC_IN_BOTH;
      else if (regMode && configReg[CFG_Q_INPUT])
         inputSel = AMC_IN_Q;
   end

   // phase from bit 14 in register control, else pin
   // non-demux allows double rate 0 degree only
   always_comb
   begin
      logic sel;
      sel = regMode ? configReg[CFG_PHASE] : phasePin;
      if (nonDemux)
         phaseSel = AMC_DDR_0;
      else if (sdrMode)
         phaseSel = sel ? AMC_SDR_RISE : AMC_SDR_FALL;
      else
         phaseSel = sel ? AMC_DDR_90 : AMC_DDR_0;
   end

   // apb: one wait state, registered answer
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else if (ce)
      begin
         pready <= apbAccess;
         pslverr <= apbAccess & ~mapped;
         if (apbAccess && !pwrite)
         begin
            unique case (paddr)
               ADDR_CONFIG: prdata <= {16'h0, configReg};
               ADDR_I_RANGE: prdata <= {16'h0, iRangeReg};
               ADDR_Q_RANGE: prdata <= {16'h0, qRangeReg};
               ADDR_STATUS: prdata <= {16'h0, statusWord};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   // registers held at reset values while pin control is selected
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         configReg <= CONFIG_RESET;
         iRangeReg <= RANGE_RESET;
         qRangeReg <= RANGE_RESET;
      end
      else if (ce)
      begin
         if (!regMode)
         begin
            configReg <= CONFIG_RESET;
            iRangeReg <= RANGE_RESET;
            qRangeReg <= RANGE_RESET;
         end
         else if (apbDone && pwrite)
         begin
            if (paddr == ADDR_CONFIG)
               configReg <= pwdata[REG_W-1:0];
            if (paddr == ADDR_I_RANGE)
               iRangeReg <= pwdata[REG_W-1:0];
            if (paddr == ADDR_Q_RANGE)
               qRangeReg <= pwdata[REG_W-1:0];
         end
      end
   end

   // pin control fixes both channels at RANGE_RESET; registers split them
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         iRange <= RANGE_RESET;
         qRange <= RANGE_RESET;
      end
      else if (ce)
      begin
         iRange <= regMode ? iRangeReg : RANGE_RESET;
         qRange <= regMode ? qRangeReg : RANGE_RESET;
      end
   end

   // calibration request: low hold then high hold, rising edge of combined level
   logic calLevel;
   logic calLevelPrev;
   logic [CNT_W-1:0] lowCount;
   logic [CNT_W-1:0] highCount;
   logic armed;
   logic calRequest;

   assign calLevel = trimPin | calBit;

   // qualify the request by the hold times the controller keeps
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         calLevelPrev <= 1'b0;
         lowCount <= '0;
         highCount <= '0;
         armed <= 1'b0;
         calRequest <= 1'b0;
      end
      else if (ce)
      begin
         calLevelPrev <= calLevel;
         calRequest <= 1'b0;
         if (!calLevel)
         begin
            highCount <= '0;
            lowCount <= satInc(lowCount, LOW_MAX);
            if (lowCount >= LOW_MAX - 1'b1)
               armed <= 1'b1;
         end
         else
         begin
            lowCount <= '0;
            highCount <= satInc(highCount, HIGH_MAX);
            if (calLevelPrev && armed && highCount >= HIGH_MAX - 1'b1)
            begin
               calRequest <= 1'b1;
               armed <= 1'b0;
            end
            else if (!calLevelPrev && !armed)
               armed <= 1'b0;
         end
      end
   end

   // power-on wait, calibration run and pipeline flush
   amc_state_t state;
   logic [CNT_W-1:0] seqCount;
   logic porCaught;
   logic porSkipped;
   logic iSleepPrev;
   logic qSleepPrev;
   logic wake;
   logic recalAdvised;
   logic [REG_W-1:0] iRangePrev;
   logic [REG_W-1:0] qRangePrev;

   assign wake = (iSleepPrev & ~iSleep) | (qSleepPrev & ~qSleep);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= AMC_POR_WAIT;
         seqCount <= '0;
         porCaught <= 1'b0;
         porSkipped <= 1'b0;
         iSleepPrev <= 1'b1;
         qSleepPrev <= 1'b1;
      end
      else if (ce)
      begin
         iSleepPrev <= iSleep;
         qSleepPrev <= qSleep;
         unique case (state)
            AMC_POR_WAIT:
            begin
               seqCount <= seqCount + 1'b1;
               // request high at power-up skips calibration
               if (!porCaught && seqCount == CNT_W'(2))
               begin
                  porCaught <= 1'b1;
                  porSkipped <= trimPin;
               end
               // short or long wait before power-on calibration
               if (porCaught && porSkipped)
               begin
                  state <= AMC_FLUSH;
                  seqCount <= '0;
               end
               else if (seqCount >= (delayPin ? CNT_W'(WAIT_LONG - 1) : CNT_W'(WAIT_SHORT - 1)))
               begin
                  state <= AMC_CAL;
                  seqCount <= '0;
               end
            end
            AMC_CAL:
            begin
               seqCount <= seqCount + 1'b1;
               if (seqCount >= CNT_W'(CAL_CYCLES - 1))
               begin
                  state <= AMC_FLUSH;
                  seqCount <= '0;
               end
            end
            AMC_FLUSH, AMC_RUN:
            begin
               seqCount <= (state == AMC_FLUSH) ? seqCount + 1'b1 : '0;
               if (calRequest)
               begin
                  state <= AMC_CAL;
                  seqCount <= '0;
               end
               else if (wake)
               begin
                  state <= AMC_FLUSH;
                  seqCount <= '0;
               end
               else if (state == AMC_FLUSH && seqCount >= CNT_W'(FLUSH_CYCLES - 1))
                  state <= AMC_RUN;
            end
         endcase
      end
   end

   // advisory: recalibrate after wake, sleep entry or range change; set wins
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         recalAdvised <= 1'b0;
         iRangePrev <= RANGE_RESET;
         qRangePrev <= RANGE_RESET;
      end
      else if (ce)
      begin
         iRangePrev <= iRange;
         qRangePrev <= qRange;
         if (wake || (iSleep & ~iSleepPrev) || (qSleep & ~qSleepPrev)
             || iRange != iRangePrev || qRange != qRangePrev)
            recalAdvised <= 1'b1;
         else if (state == AMC_CAL)
            recalAdvised <= 1'b0;
      end
   end

   assign statusWord = {1'b0, porSkipped, recalAdvised, ~rangePin, pattern, qSleep, iSleep,
                        phaseSel, inputSel, nonDemux, interleave, regMode, dataValid, calRunning};

   // output path
   logic [DATA_W-1:0] patternCount;
   logic [DATA_W-1:0] iHeld;
   logic [DATA_W-1:0] qHeld;
   logic half;
   logic [DATA_W-1:0] iSrc;
   logic [DATA_W-1:0] qSrc;
   logic iOvSrc;
   logic qOvSrc;
   logic update;
   logic strobeStep;

   // test pattern replaces converter on buses and overrange
   assign iSrc = pattern ? patternCount : iSample;
   assign qSrc = pattern ? ~patternCount : qSample;
   assign iOvSrc = pattern ? patternCount[0] : iSampleOver;
   assign qOvSrc = pattern ? ~patternCount[0] : qSampleOver;
   // non-demux updates every cycle, demux every second cycle
   assign update = nonDemux | half;
   // 0 degree steps strobe with data, 90 degree between updates
   always_comb
   begin
      unique case (phaseSel)
         AMC_DDR_0: strobeStep = update;
         AMC_DDR_90: strobeStep = ~half;
         AMC_SDR_FALL, AMC_SDR_RISE: strobeStep = 1'b1;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         patternCount <= '0;
         half <= 1'b0;
         iHeld <= '0;
         qHeld <= '0;
         iOutBus <= '0;
         iOutBusEarly <= '0;
         qOutBus <= '0;
         qOutBusEarly <= '0;
         iOverrange <= 1'b0;
         qOverrange <= 1'b0;
      end
      else if (ce)
      begin
         patternCount <= patternCount + 1'b1;
         // pin alone picks the demux mode
         half <= nonDemux ? 1'b0 : ~half;
         iHeld <= iSrc;
         qHeld <= qSrc;
         if (state == AMC_CAL)
         begin
            iOutBus <= '0;
            iOutBusEarly <= '0;
            qOutBus <= '0;
            qOutBusEarly <= '0;
            iOverrange <= 1'b0;
            qOverrange <= 1'b0;
         end
         else if (update)
         begin
            // demux pairs older sample onto early bus
            // early buses idle in non-demux mode
            iOutBus <= iSrc;
            qOutBus <= qSrc;
            iOutBusEarly <= nonDemux ? '0 : iHeld;
            qOutBusEarly <= nonDemux ? '0 : qHeld;
            iOverrange <= iOvSrc;
            qOverrange <= qOvSrc;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         iOutputStrobe <= 1'b0;
         qOutputStrobe <= 1'b0;
         iOutEnable <= 1'b0;
         qOutEnable <= 1'b0;
         calRunning <= 1'b0;
         dataValid <= 1'b0;
      end
      else if (ce)
      begin
         if (strobeStep)
         begin
            iOutputStrobe <= ~iOutputStrobe;
            qOutputStrobe <= ~iOutputStrobe;
         end
         iOutEnable <= ~iSleep;
         qOutEnable <= ~qSleep;
         calRunning <= (state == AMC_CAL);
         dataValid <= (state == AMC_RUN) && !calRequest && !wake;
      end
   end
endmodule // amc_mode_ctrl

// ---- tb/amc_mode_checker.sv ----
`timescale 1ns/10ps
module amc_mode_checker
   import amc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic serialControlEnableN,
   input wire logic nonDemuxSelect,
   input wire logic iPathSleep,
   input wire logic qPathSleep,
   input wire logic patternOutputSelect,
   input wire logic [DATA_W-1:0] iOutBus,
   input wire logic [DATA_W-1:0] iOutBusEarly,
   input wire logic [DATA_W-1:0] qOutBus,
   input wire logic iOutEnable,
   input wire logic qOutEnable,
   input wire logic iOutputStrobe,
   input wire logic qOutputStrobe,
   input wire logic dataValid,
   input wire logic [REG_W-1:0] iRange
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   early_idle_a:
   assert property (nonDemuxSelect [*4] |-> iOutBusEarly == 12'h000)
      else $error("early bus busy");
   strobe_pair_a:
   assert property (iOutputStrobe == qOutputStrobe)
      else $error("strobes differ");
   i_sleep_a:
   assert property (iPathSleep [*4] |-> !iOutEnable)
      else $error("i bus driven asleep");
   q_sleep_a:
   assert property (qPathSleep [*4] |-> !qOutEnable)
      else $error("q bus driven asleep");
   flush_hold_a:
   assert property ($rose(iOutEnable) |=> !dataValid [*8])
      else $error("valid before flush");
   pattern_pair_a:
   assert property (patternOutputSelect [*5] ##0 (dataValid && iOutEnable && qOutEnable) |-> qOutBus == ~iOutBus)
      else $error("pattern mismatch");
   pin_range_a:
   assert property (serialControlEnableN [*4] |-> iRange == RANGE_RESET)
      else $error("range not fixed");
   sync_delay_a:
   assert property ($rose(iPathSleep) |=> $stable(iOutEnable))
      else $error("sleep pin unsynced");
   cover property ($fell(iOutEnable));
   cover property ($rose(dataValid));
   cover property (patternOutputSelect && dataValid);
endmodule // amc_mode_checker
bind amc_mode_ctrl amc_mode_checker chk_i (.*);

// ---- tb/amc_board.sv ----
`timescale 1ns/10ps
module amc_board (
   input wire logic mclk,
   output logic serialControlEnableN,
   output logic dualEdgeSelect,
   output logic nonDemuxSelect,
   output logic ddrPhaseSelect,
   output logic trimCycleRequest,
   output logic trimStartDelaySelect,
   output logic iPathSleep,
   output logic qPathSleep,
   output logic patternOutputSelect,
   output logic inputRangeSelect
);
   logic [9:0] pins = 10'h201;
   assign {serialControlEnableN, dualEdgeSelect, nonDemuxSelect, ddrPhaseSelect, trimCycleRequest,
      trimStartDelaySelect, iPathSleep, qPathSleep, patternOutputSelect, inputRangeSelect} = pins;
   // delay set only around reset, range high
   task automatic put(input logic [9:0] v);
      pins <= v | 10'h001;
      @(posedge mclk);
   endtask
   task automatic trim(input int lo, input int hi);
      pins[5] <= 1'b0;
      repeat (lo) @(posedge mclk);
      pins[5] <= 1'b1;
      repeat (hi) @(posedge mclk);
   endtask
endmodule // amc_board

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench
   import amc_pkg::*;
();
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [DATA_W-1:0] iSample = 12'h000;
   logic [DATA_W-1:0] qSample = 12'h000;
   logic iSampleOver = 1'b0;
   logic qSampleOver = 1'b0;
   logic [31:0] prdata, r;
   logic pready, pslverr, e;
   wire serialControlEnableN, dualEdgeSelect, nonDemuxSelect, ddrPhaseSelect;
   wire trimCycleRequest, trimStartDelaySelect, iPathSleep, qPathSleep, patternOutputSelect, inputRangeSelect;
   logic [DATA_W-1:0] iOutBus, iOutBusEarly, qOutBus, qOutBusEarly;
   logic iOutEnable, qOutEnable, iOverrange, qOverrange, iOutputStrobe, qOutputStrobe, calRunning, dataValid;
   logic [REG_W-1:0] iRange, qRange;
   int num_errors = 0;
   int checks = 0;
   amc_mode_ctrl #(.LOW_HOLD(4), .HIGH_HOLD(4), .CAL_CYCLES(16), .WAIT_SHORT(32), .WAIT_LONG(64)) dut (.*);
   amc_board brd (.*);
   always #4 mclk = ~mclk;
   always @(posedge mclk)
   begin
      iSample <= iSample + 12'h001;
      qSample <= qSample + 12'h003;
      // overrange follows bit 0 of the i sample and its inverse on q
      iSampleOver <= ~iSample[0];
      qSampleOver <= qSample[0];
   end
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x)
      begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
      begin
         @(posedge mclk);
         n++;
         if (n > 20)
         begin
            chk(n, 0);
            test_done;
         end
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r & m, x);
   endtask
   task automatic wt(input int s, input logic v, input int lim);
      int n;
      logic x;
      n = 0;
      x = ~v;
      while (x !== v)
      begin
         @(posedge mclk);
         x = s == 0 ? dataValid : s == 1 ? calRunning : s == 2 ? iOutEnable : qOutEnable;
         n++;
         if (n > lim)
         begin
            chk(s, 99);
            test_done;
         end
      end
      checks++;
   endtask
   task automatic s_por(input logic [9:0] v, input int lo, input int hi);
      int n;
      brd.put(v);
      resetn <= 1'b0;
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      n = 0;
      while (dataValid !== 1'b1 && n < 300)
      begin
         @(posedge mclk);
         n++;
      end
      chk(n >= lo && n <= hi, 1);
   endtask
   task automatic s_pins;
      for (int k = 0; k < 4; k++)
      begin
         brd.put({2'b10, k[1:0], 6'h01});
         repeat (4) @(posedge mclk);
         rdc(ADDR_STATUS, 32'h01fc, {23'h0, k[1] ? 2'b00 : {1'b0, k[0]}, 2'b00, k[1], 4'h0});
      end
      brd.put(10'h301);
      repeat (4) @(posedge mclk);
      rdc(ADDR_STATUS, 32'h0078, 32'h0008);
      brd.put(10'h203);
      repeat (8) @(posedge mclk);
      rdc(ADDR_STATUS, 32'h0800, 32'h0800);
   endtask
   task automatic s_rate(input logic [9:0] v, input int x);
      int n;
      int ns;
      logic [DATA_W-1:0] p;
      logic s;
      brd.put(v);
      repeat (4) @(posedge mclk);
      wt(0, 1'b1, 200);
      n = 0;
      ns = 0;
      p = iOutBus;
      s = iOutputStrobe;
      repeat (8)
      begin
         @(posedge mclk);
         if (iOutBus !== p)
            n++;
         if (iOutputStrobe !== s)
            ns++;
         p = iOutBus;
         s = iOutputStrobe;
      end
      chk(n, x);
      chk(ns, x);
      chk({31'h0, iOverrange}, {31'h0, iOutBus[0]});
      chk({31'h0, qOverrange}, {31'h0, ~qOutBus[0]});
      chk({20'h0, iOutBusEarly}, x == 4 ? {20'h0, iOutBus - 12'h001} : 32'h0);
      chk({20'h0, qOutBusEarly}, x == 4 ? {20'h0, qOutBus - 12'h003} : 32'h0);
      // clock enable low freezes the output path
      ce <= 1'b0;
      @(posedge mclk);
      p = iOutBus;
      repeat (4) @(posedge mclk);
      chk({20'h0, iOutBus}, {20'h0, p});
      ce <= 1'b1;
   endtask
   task automatic s_reg;
      brd.put(10'h001);
      rdc(ADDR_CONFIG, 32'hffff, 32'h2000);
      rdc(ADDR_Q_RANGE, 32'hffff, 32'h4000);
      apb(1'b1, ADDR_CONFIG, 32'h60c0);
      rdc(ADDR_STATUS, 32'h01fc, 32'h00ac);
      brd.put(10'h081);
      repeat (4) @(posedge mclk);
      rdc(ADDR_STATUS, 32'h0190, 32'h0010);
      apb(1'b1, ADDR_CONFIG, 32'h20a0);
      rdc(ADDR_STATUS, 32'h0060, 32'h0040);
      apb(1'b1, ADDR_I_RANGE, 32'h1234);
      apb(1'b1, ADDR_Q_RANGE, 32'h0abc);
      @(posedge mclk);
      chk({16'h0, iRange}, 32'h1234);
      chk({16'h0, qRange}, 32'h0abc);
      rdc(8'h10, 32'hffffffff, 32'h0);
      chk(e, 1);
      brd.put(10'h201);
      repeat (4) @(posedge mclk);
      apb(1'b1, ADDR_CONFIG, 32'h0080);
      rdc(ADDR_CONFIG, 32'hffff, 32'h2000);
      chk({16'h0, iRange}, 32'h4000);
      chk({16'h0, qRange}, 32'h4000);
   endtask
   task automatic s_sleep;
      brd.put(10'h209);
      wt(2, 1'b0, 8);
      chk(qOutEnable, 1);
      brd.put(10'h201);
      wt(2, 1'b1, 8);
      repeat (2) @(posedge mclk);
      chk(dataValid, 0);
      wt(0, 1'b1, 80);
      rdc(ADDR_STATUS, 32'h2000, 32'h2000);
      brd.put(10'h001);
      apb(1'b1, ADDR_CONFIG, 32'h2400);
      wt(3, 1'b0, 8);
      apb(1'b1, ADDR_CONFIG, 32'h2800);
      wt(2, 1'b0, 8);
      wt(3, 1'b1, 8);
      apb(1'b1, ADDR_CONFIG, 32'h2000);
      wt(2, 1'b1, 8);
   endtask
   task automatic s_cal;
      repeat (6) @(posedge mclk);
      apb(1'b1, ADDR_CONFIG, 32'ha000);
      wt(1, 1'b1, 20);
      wt(1, 1'b0, 40);
      rdc(ADDR_STATUS, 32'h2000, 32'h0);
      brd.put(10'h201);
      brd.trim(6, 6);
      wt(1, 1'b1, 12);
      wt(0, 1'b1, 120);
   endtask
   initial
   begin
      s_por(10'h201, 100, 125);
      s_por(10'h211, 132, 160);
      s_por(10'h221, 55, 75);
      rdc(ADDR_STATUS, 32'h4001, 32'h4000);
      s_pins;
      s_rate(10'h201, 4);
      s_rate(10'h281, 8);
      s_reg;
      s_sleep;
      s_cal;
      test_done;
   end
endmodule // testbench
